// ===== logic/tscp_pkg.sv
// Package for the transceiver serial configuration port.
// Assumes a single 250 MHz core clock domain.
package tscp_pkg;
  localparam int WORD_W = 24;
  localparam logic [4:0] SYNC_DEPTH = 5'h02;
  localparam logic [4:0] BIT_CNT_MAX = 5'h18;
  // Address bits 23, 22, 1, 0 as a nibble
  localparam int ADR_HI = 23;
  localparam int ADR_LO = 22;
  // Mode-0 word fields
  localparam int M0_BAND_LSB = 0;
  localparam int M0_CP_LSB = 2;
  localparam int M0_INV_BIT = 4;
  localparam int M0_TXRX_BIT = 5;
  localparam int PA_ATT_LSB = 6;
  // Mode-1 word fields
  localparam int M1_BOD_EN_BIT = 0;
  localparam int M1_BOD_LSB = 1;
  localparam int M1_AMP_EN_BIT = 3;
  localparam int M1_OOK_BIT = 4;
  localparam int M1_TXRX_BIT = 5;
  // Reference divider and tuning fields
  localparam int REF_DIV_LSB = 14;
  localparam int TUNE_RX_SW_BIT = 19;
  localparam int TUNE_OOK_SW_BIT = 11;
  // Reset values of the five words
  localparam logic [23:0] M0_RST = 24'h007082;
  localparam logic [23:0] M1_RST = 24'h407080;
  localparam logic [23:0] REF_RST = 24'h900000;
  localparam logic [23:0] TUNE_RST = 24'hC08000;
  localparam logic [23:0] RXC_RST = 24'hB40201;

  typedef enum logic [2:0] {TSCP_NONE, TSCP_M0, TSCP_M1, TSCP_REF, TSCP_RXC, TSCP_TUNE} tscp_sel_e;

  typedef struct packed {
    logic [1:0] band_div;
    logic [7:0] ref_div;
    logic [1:0] cp_current;
    logic [1:0] pa_atten;
    logic pa_on;
    logic xtal_sw_closed;
    logic rx_data;
    logic [1:0] bod_thresh;
    logic bod_enable;
    logic synth_power;
    logic ook_mode;
  } tscp_cfg_s;

  typedef struct packed {
    logic [2:0] clk_sync;
    logic [1:0] dat_sync;
    logic [2:0] ld_sync;
    logic [1:0] mode_sync;
    logic [1:0] stby_sync;
    logic [1:0] txd_sync;
    logic [1:0] rxd_sync;
    logic [23:0] shift;
    logic [23:0] m0;
    logic [23:0] m1;
    logic [23:0] refw;
    logic [23:0] tune;
    logic [23:0] rxc;
    tscp_cfg_s cfg;
  } tscp_state_s;
endpackage : tscp_pkg

// ===== logic/tscp_port.sv
// Serial configuration port: shifts control words in, decodes, drives config.
// Assumes the host keeps clock, data, latch and pins asynchronous to i_mclk;
// link clock is far slower than i_mclk (64 ns period vs 4 ns).
// Overview of operation
// RL1: Output divider 1/2/3 from mode-0 bits 1:0
// RL2: Reference divider is 8-bit programmable field
// RL3: FSK: crystal switch closed while TX data low
// RL4: Invert bit inverts received data output
// RL5: Host keeps tuning bit 19 high in receive
// RL6: Charge-pump current from mode-0 bits 3:2
// RL7: Standby pin high powers synth, low down
// RL8: PA attenuation from per-mode two-bit field
// RL9: Mode-1 enable bit gates PA in transmit
// RL10: Receive keeps PA off, synth running
// RL11: OOK: TX data switches PA on/off
// RL12: Brownout threshold from mode-1 field
// RL13: Five 24-bit control words hold state
// RL14: Mode pin selects mode-0 or mode-1 set
// RL15: Address from bits 23, 22, 1, 0
// RL16: Some address bits are don't-care
// RL17: Shift data in on serial clock rise
// RL18: Latch rise decodes and writes word
// RL19: Tuning and receive-control words are stored
// RL20: Decode 00xx,01xx,1000,1001,11x0
// RL21: Only latch edge updates control words
// RL22: Unmatched addresses are ignored
`timescale 1ns/100ps
`default_nettype none
module tscp_port
  import tscp_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic i_ser_clk,
  input wire logic i_ser_data,
  input wire logic i_ser_latch,
  input wire logic i_mode_pin,
  input wire logic i_standby_pin,
  input wire logic i_tx_data,
  input wire logic i_rx_slicer,
  output logic [1:0] o_band_div,
  output logic [7:0] o_ref_div,
  output logic [1:0] o_cp_current,
  output logic [1:0] o_pa_atten,
  output logic o_pa_on,
  output logic o_xtal_sw_closed,
  output logic o_rx_data,
  output logic [1:0] o_bod_thresh,
  output logic o_bod_enable,
  output logic o_synth_power,
  output logic o_ook_mode,
  output logic [23:0] o_tune_word,
  output logic [23:0] o_rx_ctrl_word
);
  tscp_state_s st_reg;
  tscp_state_s st_next;
  tscp_sel_e sel;
  logic clk_rise;
  logic ld_rise;
  logic [3:0] adr;
  logic [23:0] act;
  logic tx_mode;

  // First stage of each synchroniser feeds only the second stage
  assign clk_rise = st_reg.clk_sync[1] & ~st_reg.clk_sync[2];
  assign ld_rise = st_reg.ld_sync[1] & ~st_reg.ld_sync[2];
  assign adr = {st_reg.shift[ADR_HI], st_reg.shift[ADR_LO], st_reg.shift[1], st_reg.shift[0]}; // see RL15
  assign act = st_reg.mode_sync[1] ? st_reg.m1 : st_reg.m0; // see RL14
  assign tx_mode = act[M0_TXRX_BIT];

  always_comb begin
    casez (adr) // see RL16 see RL20
      4'b00??: sel = TSCP_M0;
      4'b01??: sel = TSCP_M1;
      4'b1000: sel = TSCP_REF;
      4'b1001: sel = TSCP_RXC;
      4'b11?0: sel = TSCP_TUNE;
      default: sel = TSCP_NONE; // see RL22
    endcase
  end

  always_comb begin
    st_next = st_reg;
    st_next.clk_sync = {st_reg.clk_sync[1:0], i_ser_clk};
    st_next.dat_sync = {st_reg.dat_sync[0], i_ser_data};
    st_next.ld_sync = {st_reg.ld_sync[1:0], i_ser_latch};
    st_next.mode_sync = {st_reg.mode_sync[0], i_mode_pin};
    st_next.stby_sync = {st_reg.stby_sync[0], i_standby_pin};
    st_next.txd_sync = {st_reg.txd_sync[0], i_tx_data};
    st_next.rxd_sync = {st_reg.rxd_sync[0], i_rx_slicer};
    // Data sync is one stage shorter than clock, so data aligns with the sampled edge
    if (clk_rise) begin
      st_next.shift = {st_reg.shift[22:0], st_reg.dat_sync[1]}; // see RL17
    end
    if (ld_rise) begin // see RL18 see RL21
      case (sel)
        TSCP_M0: st_next.m0 = st_reg.shift; // see RL13
        TSCP_M1: st_next.m1 = st_reg.shift;
        TSCP_REF: st_next.refw = st_reg.shift;
        TSCP_RXC: st_next.rxc = st_reg.shift; // see RL19
        TSCP_TUNE: st_next.tune = st_reg.shift; // see RL19
        default: ;
      endcase
    end
    st_next.cfg.band_div = st_reg.m0[M0_BAND_LSB +: 2]; // see RL1
    st_next.cfg.ref_div = st_reg.refw[REF_DIV_LSB +: 8]; // see RL2
    st_next.cfg.cp_current = st_reg.m0[M0_CP_LSB +: 2]; // see RL6
    st_next.cfg.pa_atten = act[PA_ATT_LSB +: 2]; // see RL8
    st_next.cfg.bod_thresh = st_reg.m1[M1_BOD_LSB +: 2]; // see RL12
    st_next.cfg.bod_enable = st_reg.m1[M1_BOD_EN_BIT];
    st_next.cfg.synth_power = st_reg.stby_sync[1]; // see RL7
    st_next.cfg.ook_mode = st_reg.m1[M1_OOK_BIT];
    st_next.cfg.rx_data = st_reg.rxd_sync[1] ^ st_reg.m0[M0_INV_BIT]; // see RL4
    // PA is off in receive or standby; OOK keys it with TX data
    if (!tx_mode || !st_reg.stby_sync[1]) begin
      st_next.cfg.pa_on = 1'b0; // see RL10
    end else if (st_reg.m1[M1_OOK_BIT]) begin
      st_next.cfg.pa_on = st_reg.m1[M1_AMP_EN_BIT] & st_reg.txd_sync[1]; // see RL11 see RL9
    end else begin
      st_next.cfg.pa_on = st_reg.m1[M1_AMP_EN_BIT]; // see RL9
    end
    // Receive relies on the host keeping bit 19 high
    if (!tx_mode) begin
      st_next.cfg.xtal_sw_closed = st_reg.tune[TUNE_RX_SW_BIT]; // see RL5
    end else if (st_reg.m1[M1_OOK_BIT]) begin
      st_next.cfg.xtal_sw_closed = st_reg.tune[TUNE_OOK_SW_BIT];
    end else begin
      st_next.cfg.xtal_sw_closed = ~st_reg.txd_sync[1]; // see RL3
    end
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_reg <= '0;
      st_reg.m0 <= M0_RST;
      st_reg.m1 <= M1_RST;
      st_reg.refw <= REF_RST;
      st_reg.tune <= TUNE_RST;
      st_reg.rxc <= RXC_RST;
      st_reg.cfg.band_div <= M0_RST[1:0];
      st_reg.cfg.ref_div <= REF_RST[21:14];
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_band_div = st_reg.cfg.band_div;
  assign o_ref_div = st_reg.cfg.ref_div;
  assign o_cp_current = st_reg.cfg.cp_current;
  assign o_pa_atten = st_reg.cfg.pa_atten;
  assign o_pa_on = st_reg.cfg.pa_on;
  assign o_xtal_sw_closed = st_reg.cfg.xtal_sw_closed;
  assign o_rx_data = st_reg.cfg.rx_data;
  assign o_bod_thresh = st_reg.cfg.bod_thresh;
  assign o_bod_enable = st_reg.cfg.bod_enable;
  assign o_synth_power = st_reg.cfg.synth_power;
  assign o_ook_mode = st_reg.cfg.ook_mode;
  assign o_tune_word = st_reg.tune;
  assign o_rx_ctrl_word = st_reg.rxc;

  property p_shift_on_edge;
    @(posedge i_mclk) disable iff (!i_nrst)
      clk_rise |=> st_reg.shift[0] == $past(st_reg.dat_sync[1]);
  endproperty
  a_shift_on_edge: assert property (p_shift_on_edge) else $error("shift missed serial bit"); // see RL17

  property p_hold_no_edge;
    @(posedge i_mclk) disable iff (!i_nrst)
      !clk_rise |=> $stable(st_reg.shift);
  endproperty
  a_hold_no_edge: assert property (p_hold_no_edge) else $error("shift moved without edge");

  property p_m0_write;
    @(posedge i_mclk) disable iff (!i_nrst)
      ld_rise && adr[3:2] == 2'b00 |=> st_reg.m0 == $past(st_reg.shift);
  endproperty
  a_m0_write: assert property (p_m0_write) else $error("mode-0 word not written"); // see RL18

  property p_no_latch_stable;
    @(posedge i_mclk) disable iff (!i_nrst)
      !ld_rise |=> $stable(st_reg.m0) && $stable(st_reg.m1) && $stable(st_reg.refw);
  endproperty
  a_no_latch_stable: assert property (p_no_latch_stable) else $error("word changed without latch"); // see RL21

  property p_bad_addr;
    @(posedge i_mclk) disable iff (!i_nrst)
      ld_rise && (adr == 4'b1010 || adr == 4'b1011 || adr == 4'b1101 || adr == 4'b1111)
      |=> $stable(st_reg.tune) && $stable(st_reg.rxc) && $stable(st_reg.refw);
  endproperty
  a_bad_addr: assert property (p_bad_addr) else $error("unmapped address wrote a word"); // see RL22

  property p_tune_write;
    @(posedge i_mclk) disable iff (!i_nrst)
      ld_rise && adr[3:2] == 2'b11 && !adr[0] |=> st_reg.tune == $past(st_reg.shift);
  endproperty
  a_tune_write: assert property (p_tune_write) else $error("tuning word not written"); // see RL20

  property p_rx_pa_off;
    @(posedge i_mclk) disable iff (!i_nrst)
      !tx_mode |=> !o_pa_on;
  endproperty
  a_rx_pa_off: assert property (p_rx_pa_off) else $error("PA on during receive"); // see RL10

  property p_standby;
    @(posedge i_mclk) disable iff (!i_nrst)
      st_reg.stby_sync[1] |=> o_synth_power;
  endproperty
  a_standby: assert property (p_standby) else $error("synth not powered"); // see RL7

  property p_invert;
    @(posedge i_mclk) disable iff (!i_nrst)
      1'b1 |=> o_rx_data == ($past(st_reg.rxd_sync[1]) ^ $past(st_reg.m0[M0_INV_BIT]));
  endproperty
  a_invert: assert property (p_invert) else $error("rx data polarity wrong"); // see RL4

  property p_fsk_sw;
    @(posedge i_mclk) disable iff (!i_nrst)
      tx_mode && !st_reg.m1[M1_OOK_BIT] |=> o_xtal_sw_closed == !$past(st_reg.txd_sync[1]);
  endproperty
  a_fsk_sw: assert property (p_fsk_sw) else $error("crystal switch wrong in FSK"); // see RL3

  property p_band_out;
    @(posedge i_mclk) disable iff (!i_nrst)
      1'b1 |=> o_band_div == $past(st_reg.m0[M0_BAND_LSB +: 2]);
  endproperty
  a_band_out: assert property (p_band_out) else $error("band divider wrong"); // see RL1

  property p_ref_out;
    @(posedge i_mclk) disable iff (!i_nrst)
      1'b1 |=> o_ref_div == $past(st_reg.refw[REF_DIV_LSB +: 8]);
  endproperty
  a_ref_out: assert property (p_ref_out) else $error("reference divider wrong"); // see RL2

  property p_cp_out;
    @(posedge i_mclk) disable iff (!i_nrst)
      1'b1 |=> o_cp_current == $past(st_reg.m0[M0_CP_LSB +: 2]);
  endproperty
  a_cp_out: assert property (p_cp_out) else $error("charge pump code wrong"); // see RL6

  property p_att_mode0;
    @(posedge i_mclk) disable iff (!i_nrst)
      !st_reg.mode_sync[1] |=> o_pa_atten == $past(st_reg.m0[PA_ATT_LSB +: 2]);
  endproperty
  a_att_mode0: assert property (p_att_mode0) else $error("mode-0 attenuation wrong"); // see RL8

  property p_att_mode1;
    @(posedge i_mclk) disable iff (!i_nrst)
      st_reg.mode_sync[1] |=> o_pa_atten == $past(st_reg.m1[PA_ATT_LSB +: 2]);
  endproperty
  a_att_mode1: assert property (p_att_mode1) else $error("mode-1 attenuation wrong"); // see RL14

  property p_amp_off;
    @(posedge i_mclk) disable iff (!i_nrst)
      !st_reg.m1[M1_AMP_EN_BIT] |=> !o_pa_on;
  endproperty
  a_amp_off: assert property (p_amp_off) else $error("PA on while disabled"); // see RL9

  property p_pa_tx;
    @(posedge i_mclk) disable iff (!i_nrst)
      tx_mode && st_reg.stby_sync[1] && !st_reg.m1[M1_OOK_BIT] && st_reg.m1[M1_AMP_EN_BIT] |=> o_pa_on;
  endproperty
  a_pa_tx: assert property (p_pa_tx) else $error("PA off in FSK transmit"); // see RL9

  property p_ook_key;
    @(posedge i_mclk) disable iff (!i_nrst)
      tx_mode && st_reg.m1[M1_OOK_BIT] && !st_reg.txd_sync[1] |=> !o_pa_on;
  endproperty
  a_ook_key: assert property (p_ook_key) else $error("PA on for OOK space"); // see RL11

  property p_pa_standby;
    @(posedge i_mclk) disable iff (!i_nrst)
      !st_reg.stby_sync[1] |=> !o_synth_power && !o_pa_on;
  endproperty
  a_pa_standby: assert property (p_pa_standby) else $error("powered during standby"); // see RL7

  property p_bod_out;
    @(posedge i_mclk) disable iff (!i_nrst)
      1'b1 |=> o_bod_thresh == $past(st_reg.m1[M1_BOD_LSB +: 2]) && o_bod_enable == $past(st_reg.m1[M1_BOD_EN_BIT]);
  endproperty
  a_bod_out: assert property (p_bod_out) else $error("brownout setting wrong"); // see RL12

  property p_ook_out;
    @(posedge i_mclk) disable iff (!i_nrst)
      1'b1 |=> o_ook_mode == $past(st_reg.m1[M1_OOK_BIT]);
  endproperty
  a_ook_out: assert property (p_ook_out) else $error("modulation flag wrong"); // see RL11

  property p_rx_xtal;
    @(posedge i_mclk) disable iff (!i_nrst)
      !tx_mode |=> o_xtal_sw_closed == $past(st_reg.tune[TUNE_RX_SW_BIT]);
  endproperty
  a_rx_xtal: assert property (p_rx_xtal) else $error("receive crystal switch wrong"); // see RL19

  property p_m1_write;
    @(posedge i_mclk) disable iff (!i_nrst)
      ld_rise && adr[3:2] == 2'h1 |=> st_reg.m1 == $past(st_reg.shift);
  endproperty
  a_m1_write: assert property (p_m1_write) else $error("mode-1 word not written"); // see RL16

  property p_ref_write;
    @(posedge i_mclk) disable iff (!i_nrst)
      ld_rise && adr == 4'h8 |=> st_reg.refw == $past(st_reg.shift);
  endproperty
  a_ref_write: assert property (p_ref_write) else $error("reference word not written"); // see RL20

  property p_rxc_write;
    @(posedge i_mclk) disable iff (!i_nrst)
      ld_rise && adr == 4'h9 |=> st_reg.rxc == $past(st_reg.shift);
  endproperty
  a_rxc_write: assert property (p_rxc_write) else $error("receive control word not written"); // see RL19

  property p_no_latch_rest;
    @(posedge i_mclk) disable iff (!i_nrst)
      !ld_rise |=> $stable(st_reg.tune) && $stable(st_reg.rxc);
  endproperty
  a_no_latch_rest: assert property (p_no_latch_rest) else $error("word changed without latch"); // see RL21

  property p_bad_mode;
    @(posedge i_mclk) disable iff (!i_nrst)
      ld_rise && (adr == 4'hA || adr == 4'hB || adr == 4'hD || adr == 4'hF) |=> $stable(st_reg.m0) && $stable(st_reg.m1);
  endproperty
  a_bad_mode: assert property (p_bad_mode) else $error("unmapped address wrote a mode word"); // see RL22

  property p_shift_msb;
    @(posedge i_mclk) disable iff (!i_nrst)
      clk_rise |=> st_reg.shift[23:1] == $past(st_reg.shift[22:0]);
  endproperty
  a_shift_msb: assert property (p_shift_msb) else $error("shift register lost a bit"); // see RL17

  property p_m0_not_m1;
    @(posedge i_mclk) disable iff (!i_nrst)
      ld_rise && adr[3:2] == 2'h1 |=> $stable(st_reg.m0);
  endproperty
  a_m0_not_m1: assert property (p_m0_not_m1) else $error("mode-1 write hit mode-0 word"); // see RL20

  property p_ref_not_rxc;
    @(posedge i_mclk) disable iff (!i_nrst)
      ld_rise && adr == 4'h9 |=> $stable(st_reg.refw);
  endproperty
  a_ref_not_rxc: assert property (p_ref_not_rxc) else $error("receive control write hit reference"); // see RL20

  c_m0: cover property (@(posedge i_mclk) disable iff (!i_nrst) ld_rise && sel == TSCP_M0);
  c_m1: cover property (@(posedge i_mclk) disable iff (!i_nrst) ld_rise && sel == TSCP_M1);
  c_bad: cover property (@(posedge i_mclk) disable iff (!i_nrst) ld_rise && sel == TSCP_NONE);
  c_mode: cover property (@(posedge i_mclk) disable iff (!i_nrst) $rose(st_reg.mode_sync[1]));
  c_ook: cover property (@(posedge i_mclk) disable iff (!i_nrst) tx_mode && st_reg.m1[M1_OOK_BIT] && st_reg.txd_sync[1]);
endmodule : tscp_port
`default_nettype wire

// ===== test/tscp_host_model.sv
// Host model driving the three-wire configuration link.
// Assumes the bench calls send_word; the link clock stands low between frames.
`timescale 1ns/100ps
`default_nettype none
module tscp_host_model (
  output logic o_ser_clk,
  output logic o_ser_data,
  output logic o_ser_latch
);
  initial begin
    o_ser_clk = 1'b0;
    o_ser_data = 1'b0;
    o_ser_latch = 1'b0;
  end

  // Half period 32 ns; data moves only while the clock is low
  task automatic send_word(input logic [23:0] w, input logic latch);
    for (int i = 23; i >= 0; i--) begin
      o_ser_data = w[i];
      #32 o_ser_clk = 1'b1;
      #32 o_ser_clk = 1'b0;
    end
    // Released data line: show the inverse so a stale level is never trusted
    o_ser_data = ~w[0];
    if (latch) begin
      #32 o_ser_latch = 1'b1;
      #32 o_ser_latch = 1'b0;
    end
    #32;
  endtask : send_word
endmodule : tscp_host_model
`default_nettype wire

// ===== test/tscp_port_tb.sv
// Self-checking bench for the serial configuration port.
// Assumes the host model file is compiled first; pins change 1 ns after mclk rise.
`timescale 1ns/100ps
`default_nettype none
module tscp_port_tb;
  import tscp_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic mode = 1'b0;
  logic stby = 1'b1;
  logic txd = 1'b0;
  logic rxs = 1'b0;
  logic sck, sdat, slat, pa_on, xtal, rxd, bod_en, synth, ook;
  logic [1:0] band, cp, att, bod;
  logic [7:0] refd;
  logic [23:0] tune, rxc;
  int n_fail = 0;
  int cmp_count = 0;

  always #2 clk = ~clk;

  tscp_host_model host_u (.o_ser_clk(sck), .o_ser_data(sdat), .o_ser_latch(slat));
  tscp_port dut_u (.i_mclk(clk), .i_nrst(nrst), .i_ser_clk(sck), .i_ser_data(sdat),
    .i_ser_latch(slat), .i_mode_pin(mode), .i_standby_pin(stby), .i_tx_data(txd),
    .i_rx_slicer(rxs), .o_band_div(band), .o_ref_div(refd), .o_cp_current(cp),
    .o_pa_atten(att), .o_pa_on(pa_on), .o_xtal_sw_closed(xtal), .o_rx_data(rxd),
    .o_bod_thresh(bod), .o_bod_enable(bod_en), .o_synth_power(synth), .o_ook_mode(ook),
    .o_tune_word(tune), .o_rx_ctrl_word(rxc));

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [23:0] w);
    host_u.send_word(w, 1'b1);
    tick(2);
  endtask : wr

  task automatic pins(input logic m, input logic s, input logic t);
    mode = m;
    stby = s;
    txd = t;
    tick(6);
  endtask : pins

  task automatic tally_and_finish();
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic t_reset();
    chk("band", 24'h2, {22'h0, band});
    chk("ref", 24'h40, {16'h0, refd});
    chk("tune", 24'hC08000, tune);
    chk("rxc", 24'hB40201, rxc);
    chk("bod", 24'h0, {22'h0, bod});
  endtask : t_reset

  task automatic t_mode0();
    for (int i = 0; i < 3; i++) begin
      wr(24'h0000F0 | 24'(i * 5));
      chk("band", 24'(i), {22'h0, band});
      chk("cp", 24'(i), {22'h0, cp});
    end
    rxs = 1'b1;
    tick(6);
    chk("rxd", 24'h0, {23'h0, rxd});
  endtask : t_mode0

  task automatic t_words();
    wr(24'hA94000);
    chk("ref", 24'hA5, {16'h0, refd});
    wr(24'h9C4081);
    chk("rxc", 24'h9C4081, rxc);
    wr(24'hC80000);
    chk("tune", 24'hC80000, tune);
    wr(24'hC80802);
    chk("tune", 24'hC80802, tune);
  endtask : t_words

  task automatic t_ignore();
    // Bits shifted with no latch must leave the mode-0 word alone
    host_u.send_word(24'h000003, 1'b0);
    tick(10);
    chk("band", 24'h2, {22'h0, band});
    wr(24'h800002);
    chk("ref", 24'hA5, {16'h0, refd});
    chk("tune", 24'hC80802, tune);
  endtask : t_ignore

  task automatic t_modes();
    wr(24'h0000F5);
    wr(24'h40006D);
    pins(1'b0, 1'b1, 1'b0);
    chk("att0", 24'h3, {22'h0, att});
    pins(1'b1, 1'b1, 1'b0);
    chk("att1", 24'h1, {22'h0, att});
    chk("bod", 24'h2, {22'h0, bod});
    chk("bod_en", 24'h1, {23'h0, bod_en});
  endtask : t_modes

  task automatic t_pa();
    pins(1'b0, 1'b1, 1'b0);
    chk("pa", 24'h1, {23'h0, pa_on});
    chk("xtal", 24'h1, {23'h0, xtal});
    pins(1'b0, 1'b1, 1'b1);
    chk("xtal", 24'h0, {23'h0, xtal});
    wr(24'h400065);
    chk("pa", 24'h0, {23'h0, pa_on});
    wr(24'h40007D);
    pins(1'b1, 1'b1, 1'b1);
    chk("ook", 24'h1, {23'h0, ook});
    chk("pa", 24'h1, {23'h0, pa_on});
    pins(1'b1, 1'b1, 1'b0);
    chk("pa", 24'h0, {23'h0, pa_on});
    // Receive in mode 0; tune bit 19 was left high by the host
    pins(1'b0, 1'b1, 1'b0);
    wr(24'h0000D5);
    chk("pa", 24'h0, {23'h0, pa_on});
    chk("synth", 24'h1, {23'h0, synth});
    chk("xtal", 24'h1, {23'h0, xtal});
    pins(1'b0, 1'b0, 1'b0);
    chk("synth", 24'h0, {23'h0, synth});
    pins(1'b0, 1'b1, 1'b0);
    chk("synth", 24'h1, {23'h0, synth});
  endtask : t_pa

  initial begin
    #200000;
    n_fail++;
    tally_and_finish();
  end

  initial begin
    repeat (8) @(posedge clk);
    #1;
    nrst = 1'b1;
    tick(6);
    t_reset();
    t_mode0();
    t_words();
    t_ignore();
    t_modes();
    t_pa();
    tally_and_finish();
  end
endmodule : tscp_port_tb
`default_nettype wire
